// ---- rtl/ptsd_pkg.sv ----
package ptsd_pkg;
  // ---------------------------------------------------------------
  // register map, byte offsets on the plain register port
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h04;   // command low, status high
  localparam logic [7:0] OFS_LAT = 8'h0C;   // latency timer in [15:8]
  localparam logic [7:0] OFS_BAR0 = 8'h10;  // lower half of 64-bit bar
  localparam logic [7:0] OFS_BAR1 = 8'h14;  // upper half of 64-bit bar
  localparam logic [7:0] OFS_MSTAT = 8'h40; // master termination status
  // field positions inside those words
  localparam int CMD_MEN_BIT = 2;           // master enable
  localparam int STAT_TABORT_BIT = 28;      // status bit 12 of the word
  localparam int STAT_MABORT_BIT = 29;      // status bit 13 of the word
  localparam int LAT_LSB = 8;
  localparam int MST_LAT_BIT = 4;
  localparam int MST_RETRY_BIT = 5;
  localparam int MST_DISC_ND_BIT = 6;
  localparam int MST_DISC_D_BIT = 7;
  localparam int BAR_LSB = 20;              // 1 MiB memory window
  // reset values
  localparam logic [7:0] RST_LAT = 8'h00;
  localparam logic [31:0] RST_BAR = 32'h0000_0000;
  // ---------------------------------------------------------------
  // bus commands and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_DAC = 4'hD;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [2:0] MABORT_CLKS = 3'h5; // clocks waited for a claim
  // master sequencer, gray along idle-req-adr1-adr2-data-turn
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_REQ = 3'b001,
    M_ADR1 = 3'b011,
    M_ADR2 = 3'b010,
    M_DATA = 3'b110,
    M_TURN = 3'b111
  } ptsd_mst_t;
endpackage

// ---- rtl/ptsd_dec_if.sv ----
interface ptsd_dec_if;
  logic frame_n;       // bus frame as seen on the pins
  logic req64_n;       // bus wide-data request
  logic idsel;         // configuration select
  logic [63:0] ad;     // bus address/data
  logic [7:0] cbe;     // bus command/byte enables
  logic [63:0] bar;    // 64-bit base pair
  logic claim;         // one-cycle pulse: decode hit
  logic dac;           // current cycle used two address phases
  logic wide;          // wide data requested with the address
  logic cfg;           // configuration cycle
  logic cfg_wr;        // configuration write
  logic [5:0] cfg_idx; // dword index of configuration access
  logic [63:0] addr;   // latched full address
  modport dec(input frame_n, req64_n, idsel, ad, cbe, bar,
    output claim, dac, wide, cfg, cfg_wr, cfg_idx, addr);
  modport top(output frame_n, req64_n, idsel, ad, cbe, bar,
    input claim, dac, wide, cfg, cfg_wr, cfg_idx, addr);
endinterface

// ---- rtl/ptsd_dac_decode.sv ----
module ptsd_dac_decode
  import ptsd_pkg::*;
(
  input wire core_clk,
  input wire rst,
  ptsd_dec_if.dec d
);
  // ---------------------------------------------------------------
  // address phase detection and decode
  // ---------------------------------------------------------------
  logic frame_q_ff;   // frame one clock ago
  logic ph2_ff;       // second address phase expected now
  logic [3:0] cmd_ff; // real command from the first phase
  logic claim_ff;
  logic dac_ff;
  logic wide_ff;
  logic cfg_ff;
  logic cfg_wr_ff;
  logic [5:0] idx_ff;
  logic [63:0] addr_ff;

  wire start = !d.frame_n && frame_q_ff;
  wire is_dac = d.cbe[3:0] == CMD_DAC;
  wire mem1 = d.cbe[3:1] == CMD_MEM_RD[3:1];
  wire mem2 = cmd_ff[3:1] == CMD_MEM_RD[3:1];
  wire cfg1 = d.idsel && d.cbe[3:1] == CMD_CFG_RD[3:1] &&
    d.ad[1:0] == 2'b00;
  // single address hits only when the upper base half is zero
  wire hit32 = mem1 && d.bar[63:32] == 32'h0000_0000 &&
    d.ad[31:BAR_LSB] == d.bar[31:BAR_LSB];
  // phase two carries the upper half on the low lanes
  wire [63:0] full2 = {d.ad[31:0], addr_ff[31:0]};
  wire hit64 = mem2 && full2[63:BAR_LSB] == d.bar[63:BAR_LSB];

  // latch over both phases, decision one clock after the last one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_q_ff <= 1'b1;
      ph2_ff <= 1'b0;
      cmd_ff <= 4'h0;
      claim_ff <= 1'b0;
      dac_ff <= 1'b0;
      wide_ff <= 1'b0;
      cfg_ff <= 1'b0;
      cfg_wr_ff <= 1'b0;
      idx_ff <= 6'h00;
      addr_ff <= 64'h0000_0000_0000_0000;
    end else begin
      frame_q_ff <= d.frame_n;
      claim_ff <= 1'b0;
      if (start) begin
        addr_ff <= is_dac ? d.ad : {32'h0000_0000, d.ad[31:0]};
        cmd_ff <= is_dac ? d.cbe[7:4] : d.cbe[3:0];
        wide_ff <= !d.req64_n;
        dac_ff <= is_dac;
        ph2_ff <= is_dac;
        cfg_ff <= !is_dac && cfg1;
        cfg_wr_ff <= d.cbe[0];
        idx_ff <= d.ad[7:2];
        // slow decode waits for phase two on a dual cycle
        claim_ff <= !is_dac && (hit32 || cfg1);
      end else if (ph2_ff) begin
        ph2_ff <= 1'b0;
        addr_ff[63:32] <= d.ad[31:0];
        claim_ff <= hit64;
      end
    end
  end

  assign d.claim = claim_ff;
  assign d.dac = dac_ff;
  assign d.wide = wide_ff;
  assign d.cfg = cfg_ff;
  assign d.cfg_wr = cfg_wr_ff;
  assign d.cfg_idx = idx_ff;
  assign d.addr = addr_ff;

  slow_dec_a: assert property (@(posedge core_clk) disable iff (rst)
    claim_ff && dac_ff |-> $past(ph2_ff) && !$past(start))
    else $error("dual cycle claimed before second address phase");
endmodule

// ---- rtl/ptsd_core.sv ----
module ptsd_core
  import ptsd_pkg::*;
#(
  parameter logic HOST_BRIDGE = 1'b0,  // build option
  parameter logic LAT_TIMER_OFF = 1'b0 // build option
) (
  input wire core_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output logic [31:0] reg_rdata,
  input wire local_request_narrow_n,
  input wire local_request_wide_n,
  input wire local_last_request_n,
  input wire [63:0] l_adi,
  input wire [7:0] l_cbeni,
  output logic local_addr_ack,
  output logic local_xfer,
  output logic [7:0] master_status_vector,
  output logic tabort_seen,
  output logic mabort_seen,
  output logic [1:0] target_status_vector,
  output logic [63:0] local_addr,
  input wire gnt_n,
  input wire idsel,
  input wire frame_n_i,
  input wire irdy_n_i,
  input wire trdy_n_i,
  input wire stop_n_i,
  input wire devsel_n_i,
  input wire req64_n_i,
  input wire [63:0] ad_i,
  input wire [7:0] cbe_i,
  output logic req_n,
  output logic frame_n_o,
  output logic irdy_n_o,
  output logic req64_n_o,
  output logic mst_oe_n,
  output logic [63:0] ad_o,
  output logic ad_oe_n,
  output logic [7:0] cbe_o,
  output logic devsel_n_o,
  output logic trdy_n_o,
  output logic ack64_n_o,
  output logic tgt_oe_n
);
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic cmd_men_ff;     // software master enable
  logic tab_ff;         // status bit 12, sticky
  logic mab_ff;         // status bit 13, sticky
  logic [7:0] lat_ff;   // latency timer reload
  logic [31:0] bar0_ff; // base pair, low
  logic [31:0] bar1_ff; // base pair, high
  logic [7:0] mst_ff;   // master termination flags
  logic [31:0] rdata_ff;
  logic set_tab;
  logic set_mab;
  logic tgt_ff;         // target has claimed the cycle
  ptsd_dec_if dif ();

  // host bridge forces the master on whatever software writes
  wire men = HOST_BRIDGE || cmd_men_ff;
  // inbound configuration write, possibly from our own master
  wire cfg_go = tgt_ff && dif.cfg && dif.cfg_wr && !irdy_n_i;
  wire wr_en = reg_wr || cfg_go;
  wire [7:0] wr_a = reg_wr ? reg_addr : {dif.cfg_idx, 2'b00};
  wire [31:0] wr_d = reg_wr ? reg_wdata : ad_i[31:0];
  wire wr_cmd = wr_en && wr_a == OFS_CMD;
  wire clr_tab = wr_cmd && wr_d[STAT_TABORT_BIT];
  wire clr_mab = wr_cmd && wr_d[STAT_MABORT_BIT];

  // shared read decode; unmapped offsets answer zero
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFS_CMD: begin
        v[CMD_MEN_BIT] = men;
        v[STAT_TABORT_BIT] = tab_ff;
        v[STAT_MABORT_BIT] = mab_ff;
      end
      OFS_LAT: v[LAT_LSB+:8] = lat_ff;
      OFS_BAR0: v = {bar0_ff[31:BAR_LSB], 20'h0_0004};
      OFS_BAR1: v = bar1_ff;
      OFS_MSTAT: v[7:0] = mst_ff;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // register writes; a setting event beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_men_ff <= 1'b0;
      lat_ff <= RST_LAT;
      bar0_ff <= RST_BAR;
      bar1_ff <= RST_BAR;
      tab_ff <= 1'b0;
      mab_ff <= 1'b0;
    end else begin
      if (wr_cmd) cmd_men_ff <= wr_d[CMD_MEN_BIT];
      if (wr_en && wr_a == OFS_LAT) lat_ff <= wr_d[LAT_LSB+:8];
      if (wr_en && wr_a == OFS_BAR0) bar0_ff <= wr_d;
      if (wr_en && wr_a == OFS_BAR1) bar1_ff <= wr_d;
      tab_ff <= set_tab || (tab_ff && !clr_tab);
      mab_ff <= set_mab || (mab_ff && !clr_mab);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) rdata_ff <= 32'h0000_0000;
    else rdata_ff <= reg_rd ? reg_read(reg_addr) : 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // master sequencer
  // ---------------------------------------------------------------
  ptsd_mst_t st_ff;
  logic [63:0] maddr_ff;  // captured local address
  logic [3:0] mcmd_ff;    // real command
  logic mdac_ff;          // two address phases needed
  logic mwide_ff;         // wide data asked for
  logic single_ff;        // one data phase only
  logic last_ff;          // frame already released
  logic first_ff;         // still in first data phase
  logic seen_ff;          // devsel observed this transaction
  logic lat_hit_ff;       // ending because timer ran out
  logic [2:0] wait_ff;    // clocks without a claim
  logic [7:0] latc_ff;    // running latency count
  logic ack_ff;
  logic xfer_ff;
  logic req_ff;
  logic frame_ff;
  logic irdy_ff;
  logic req64_ff;
  logic moe_ff;

  wire lreq = !local_request_narrow_n || !local_request_wide_n;
  wire ldac = l_cbeni[3:0] == CMD_DAC;
  wire [3:0] lcmd = ldac ? l_cbeni[7:4] : l_cbeni[3:0];
  wire lcfg = lcmd[3:1] == CMD_CFG_RD[3:1];
  wire bus_idle = frame_n_i && irdy_n_i;
  wire in_data = st_ff == M_DATA;
  wire dsel = !devsel_n_i;
  wire stp = !stop_n_i;
  wire trd = !trdy_n_i;
  wire xfer = dsel && trd;
  wire t_mab = !seen_ff && !dsel && wait_ff == MABORT_CLKS;
  wire t_tab = seen_ff && !dsel && stp;
  wire t_retry = dsel && stp && !trd && first_ff;
  wire t_dnd = dsel && stp && !trd && !first_ff;
  wire t_dd = dsel && stp && trd;
  // timer option removes the forced end completely
  wire t_lat = !LAT_TIMER_OFF && latc_ff == 8'h00 && gnt_n;
  wire t_norm = xfer && !stp && last_ff;
  wire t_end = t_mab || t_tab || t_retry || t_dnd || t_dd || t_norm;
  assign set_tab = in_data && t_tab;
  assign set_mab = in_data && t_mab;

  // request, address phases, data phases and turnaround
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= M_IDLE;
      maddr_ff <= 64'h0000_0000_0000_0000;
      mcmd_ff <= 4'h0;
      {mdac_ff, mwide_ff, single_ff, last_ff} <= 4'h0;
      {first_ff, seen_ff, lat_hit_ff, ack_ff} <= 4'h0;
      {xfer_ff, req64_ff} <= 2'b01;
      {req_ff, frame_ff, irdy_ff, moe_ff} <= 4'hF;
      wait_ff <= 3'h0;
      latc_ff <= 8'h00;
      mst_ff <= 8'h00;
    end else begin
      ack_ff <= 1'b0;
      xfer_ff <= 1'b0;
      unique case (st_ff)
        M_IDLE: if (men && lreq) begin
          maddr_ff <= l_adi;
          mcmd_ff <= lcmd;
          mdac_ff <= ldac;
          mwide_ff <= !local_request_wide_n && local_request_narrow_n;
          // configuration asked for on the narrow request is one dword
          single_ff <= !local_request_narrow_n && lcfg;
          ack_ff <= 1'b1;
          req_ff <= 1'b0;
          st_ff <= M_REQ;
        end
        M_REQ: if (!gnt_n && bus_idle) begin
          mst_ff[7:4] <= 4'h0;
          req_ff <= 1'b1;
          frame_ff <= 1'b0;
          moe_ff <= 1'b0;
          req64_ff <= !mwide_ff;
          latc_ff <= lat_ff;
          st_ff <= M_ADR1;
        end
        M_ADR1: st_ff <= mdac_ff ? M_ADR2 : M_DATA;
        M_ADR2: st_ff <= M_DATA;
        M_DATA: begin
          if (latc_ff != 8'h00) latc_ff <= latc_ff - 8'h01;
          if (dsel) seen_ff <= 1'b1;
          if (!seen_ff && !dsel) wait_ff <= wait_ff + 3'h1;
          if (xfer) first_ff <= 1'b0;
          xfer_ff <= xfer;
          if (t_lat && !last_ff) lat_hit_ff <= 1'b1;
          if (t_lat || !local_last_request_n) begin
            last_ff <= 1'b1;
            frame_ff <= 1'b1;
          end
          if (t_end) begin
            mst_ff[MST_LAT_BIT] <= lat_hit_ff && t_norm;
            mst_ff[MST_RETRY_BIT] <= t_retry;
            mst_ff[MST_DISC_ND_BIT] <= t_dnd;
            mst_ff[MST_DISC_D_BIT] <= t_dd;
            {frame_ff, irdy_ff, req64_ff} <= 3'h7;
            st_ff <= M_TURN;
          end
        end
        M_TURN: begin
          moe_ff <= 1'b1;
          st_ff <= M_IDLE;
        end
        default: st_ff <= M_IDLE;
      endcase
      // entering data: one-shot cycles release frame at once
      if (st_ff == M_ADR2 || (st_ff == M_ADR1 && !mdac_ff)) begin
        irdy_ff <= 1'b0;
        last_ff <= single_ff || !local_last_request_n;
        frame_ff <= single_ff || !local_last_request_n;
        {first_ff, seen_ff, lat_hit_ff} <= 3'b100;
        wait_ff <= 3'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // target side, decode in the leaf module
  // ---------------------------------------------------------------
  logic dsel_ff;
  logic ack64_ff;
  logic [1:0] tsv_ff;
  logic [63:0] laddr_ff;
  logic [63:0] ad_ff;
  logic [7:0] cbe_ff;
  logic adoe_ff;
  logic toe_ff;         // target drive enable, low while claimed

  assign dif.frame_n = frame_n_i;
  assign dif.req64_n = req64_n_i;
  assign dif.idsel = idsel;
  assign dif.ad = ad_i;
  assign dif.cbe = cbe_i;
  assign dif.bar = {bar1_ff, bar0_ff[31:BAR_LSB], 20'h0_0000};

  ptsd_dac_decode u_dec (
    .core_clk(core_clk),
    .rst(rst),
    .d(dif)
  );

  // claim stays up until the final data phase completes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tgt_ff <= 1'b0;
      dsel_ff <= 1'b1;
      ack64_ff <= 1'b1;
      tsv_ff <= 2'b00;
      toe_ff <= 1'b1;
      laddr_ff <= 64'h0000_0000_0000_0000;
    end else if (dif.claim) begin
      tgt_ff <= 1'b1;
      toe_ff <= 1'b0;
      dsel_ff <= 1'b0;
      ack64_ff <= !(dif.wide && !dif.cfg);
      // self configuration must not disturb the local target
      if (!dif.cfg) begin
        tsv_ff <= dif.dac ? 2'b11 : 2'b01;
        laddr_ff <= dif.addr;
      end
    end else if (tgt_ff && frame_n_i && !irdy_n_i) begin
      tgt_ff <= 1'b0;
      toe_ff <= 1'b1;
      dsel_ff <= 1'b1;
      ack64_ff <= 1'b1;
    end
  end

  // shared address/data drive: config read data or master phases
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ad_ff <= 64'h0000_0000_0000_0000;
      cbe_ff <= 8'h00;
      adoe_ff <= 1'b1;
    end else if (tgt_ff && dif.cfg && !dif.cfg_wr) begin
      ad_ff <= {32'h0000_0000, reg_read({dif.cfg_idx, 2'b00})};
      adoe_ff <= 1'b0;
    end else if (st_ff == M_REQ) begin
      ad_ff <= maddr_ff;
      cbe_ff <= mdac_ff ? {mcmd_ff, CMD_DAC} : {mcmd_ff, mcmd_ff};
      adoe_ff <= gnt_n || !bus_idle;
    end else if (st_ff == M_ADR1 && mdac_ff) begin
      ad_ff <= {maddr_ff[63:32], maddr_ff[63:32]};
      cbe_ff <= {mcmd_ff, mcmd_ff};
    end else if (in_data || st_ff == M_ADR1 || st_ff == M_ADR2) begin
      ad_ff <= l_adi;
      cbe_ff <= l_cbeni;
      adoe_ff <= !mcmd_ff[0] || t_end; // reads leave the lanes free
    end else begin
      adoe_ff <= 1'b1;
    end
  end

  assign reg_rdata = rdata_ff;
  assign local_addr_ack = ack_ff;
  assign local_xfer = xfer_ff;
  assign master_status_vector = mst_ff;
  assign tabort_seen = tab_ff;
  assign mabort_seen = mab_ff;
  assign target_status_vector = tsv_ff;
  assign local_addr = laddr_ff;
  assign req_n = req_ff;
  assign frame_n_o = frame_ff;
  assign irdy_n_o = irdy_ff;
  assign req64_n_o = req64_ff;
  assign mst_oe_n = moe_ff;
  assign ad_o = ad_ff;
  assign ad_oe_n = adoe_ff;
  assign cbe_o = cbe_ff;
  assign devsel_n_o = dsel_ff;
  assign trdy_n_o = dsel_ff;
  assign ack64_n_o = ack64_ff;
  assign tgt_oe_n = toe_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  start_clr_a: assert property (@(posedge core_clk) disable iff (rst)
    st_ff == M_ADR1 |-> mst_ff[7:4] == 4'h0)
    else $error("master flags not cleared at transaction start");
  retry_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    in_data && t_retry |=> st_ff == M_TURN && mst_ff[7:4] == 4'h2)
    else $error("retry not flagged");
  disc_nd_a: assert property (@(posedge core_clk) disable iff (rst)
    in_data && t_dnd |=> mst_ff[7:4] == 4'h4 ##2 mst_ff[6])
    else $error("disconnect without data not held");
  disc_d_a: assert property (@(posedge core_clk) disable iff (rst)
    in_data && t_dd |=> mst_ff[7:4] == 4'h8 && frame_n_o)
    else $error("disconnect with data not flagged");
  tab_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    tabort_seen && !clr_tab |=> tabort_seen)
    else $error("target abort flag dropped without clear");
  mab_set_a: assert property (@(posedge core_clk) disable iff (rst)
    in_data && t_mab |=> mabort_seen && st_ff == M_TURN)
    else $error("master abort not reported");
  host_men_a: assert property (@(posedge core_clk) disable iff (rst)
    HOST_BRIDGE && reg_rd && reg_addr == OFS_CMD |=> reg_rdata[2])
    else $error("master enable not fixed in host bridge");
  dual_adr_a: assert property (@(posedge core_clk) disable iff (rst)
    st_ff == M_ADR1 && mdac_ff |=> st_ff == M_ADR2 &&
    cbe_o[3:0] == cbe_o[7:4] && ad_o[31:0] == ad_o[63:32])
    else $error("second address phase malformed");
  ack_dsel_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(devsel_n_o) && $past(dif.wide && !dif.cfg) |-> !ack64_n_o)
    else $error("wide acknowledge not with claim");
  w1c_a: assert property (@(posedge core_clk) disable iff (rst)
    clr_mab && !set_mab |=> !mabort_seen)
    else $error("master abort flag not cleared by write");
  dac_tsv_a: assert property (@(posedge core_clk) disable iff (rst)
    dif.claim && dif.dac && !dif.cfg |=> target_status_vector == 2'b11)
    else $error("bar pair hit not shown");
endmodule

// ---- tb/ptsd_bus_model.sv ----
module ptsd_bus_model (
  input wire core_clk,
  input wire rst,
  input wire [2:0] mode,
  input wire req_n,
  input wire frame_n,
  input wire irdy_n,
  input wire mst_oe_n,
  output logic gnt_n,
  output logic devsel_n,
  output logic trdy_n,
  output logic stop_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // 0 nobody claims, 1 plain, 2 retry, 3 disconnect with data, 4 abort
  logic [1:0] st;
  // idle arbiter: grant follows the request one cycle later
  always @(posedge core_clk) gnt_n <= rst | req_n;
  // lines go back to their pull-up level once the bus is idle again
  always @(posedge core_clk) begin
    if (rst || (st != 2'd0 && frame_n && irdy_n)) begin
      st <= 2'd0;
      {devsel_n, trdy_n, stop_n} <= 3'b111;
    end else if (st == 2'd0 && !mst_oe_n && !frame_n && mode != 3'd0) begin
      st <= (mode == 3'd4) ? 2'd2 : 2'd1;
      devsel_n <= 1'b0;
      trdy_n <= !(mode == 3'd1 || mode == 3'd3);
      stop_n <= !(mode == 3'd2 || mode == 3'd3);
    end else if (st == 2'd2) begin
      // abort: claim shown once, then stop without claim
      st <= 2'd3;
      {devsel_n, stop_n} <= 2'b10;
    end
  end
endmodule

// ---- tb/pci_term_status_dac_decode_tb.sv ----
module pci_term_status_dac_decode_tb
  import ptsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] md;
    logic [3:0] cmd;
    logic [63:0] adr;
    logic sel;
    logic [7:0] msv;
    logic tab;
    logic mab;
  } ptsd_row_t;
  localparam logic [63:0] MA = 64'h0000_0000_4000_0000; // outside the bar
  localparam logic [63:0] HIT = 64'h0000_0002_0034_5670;
  ptsd_row_t rows [6] = '{
    '{3'd2, CMD_MEM_RD, MA, 1'b0, 8'h20, 1'b0, 1'b0},
    '{3'd1, CMD_MEM_RD, MA, 1'b0, 8'h00, 1'b0, 1'b0},
    '{3'd3, CMD_MEM_RD, MA, 1'b0, 8'h80, 1'b0, 1'b0},
    '{3'd0, CMD_CFG_RD, 64'h4, 1'b1, 8'h00, 1'b0, 1'b0},
    '{3'd4, CMD_MEM_RD, MA, 1'b0, 8'h00, 1'b1, 1'b0},
    '{3'd0, CMD_MEM_RD, MA, 1'b0, 8'h00, 1'b1, 1'b1}};
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, l_cbeni = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic local_request_narrow_n = 1'b1, local_request_wide_n = 1'b1;
  logic local_last_request_n = 1'b1, idsel = 1'b0;
  logic [63:0] l_adi = 64'h0, local_addr, ad_o, tb_ad = 64'h0;
  logic local_addr_ack, local_xfer, tabort_seen, mabort_seen, gnt_n;
  logic [7:0] master_status_vector, cbe_o, tb_cbe = 8'h00;
  logic [1:0] target_status_vector;
  logic req_n, frame_n_o, irdy_n_o, req64_n_o, mst_oe_n, ad_oe_n;
  logic devsel_n_o, trdy_n_o, ack64_n_o, tgt_oe_n;
  logic tb_frame_n = 1'b1, tb_irdy_n = 1'b1, tb_req64_n = 1'b1;
  logic tb_drv = 1'b0, m_devsel_n, m_trdy_n, m_stop_n;
  logic [71:0] tb_noise = 72'h00_0000_0000_0000_0000;
  logic [2:0] mode = 3'd0;
  wire frame_n_i, irdy_n_i, trdy_n_i, stop_n_i, devsel_n_i, req64_n_i;
  wire [63:0] ad_i;
  wire [7:0] cbe_i;
  int num_errors = 0, n_compared = 0;
  // bus levels: whoever enables its drivers wins, else the bench side
  assign frame_n_i = mst_oe_n ? tb_frame_n : frame_n_o;
  assign irdy_n_i = mst_oe_n ? tb_irdy_n : irdy_n_o;
  assign req64_n_i = mst_oe_n ? tb_req64_n : req64_n_o;
  assign ad_i = ad_oe_n ? (tb_drv ? tb_ad : tb_noise[71:8]) : ad_o;
  assign cbe_i = ad_oe_n ? (tb_drv ? tb_cbe : tb_noise[7:0]) : cbe_o;
  assign devsel_n_i = tgt_oe_n ? m_devsel_n : devsel_n_o;
  assign trdy_n_i = tgt_oe_n ? m_trdy_n : trdy_n_o;
  assign stop_n_i = m_stop_n;
  always #2.5 core_clk = ~core_clk;
  // undriven ad/cbe keep changing so stale values cannot pass
  always @(posedge core_clk) tb_noise <= ~tb_noise;
  ptsd_core #(.HOST_BRIDGE(1'b1), .LAT_TIMER_OFF(1'b0)) ptsd_core_i (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .local_request_narrow_n, .local_request_wide_n, .local_last_request_n,
    .l_adi, .l_cbeni, .local_addr_ack, .local_xfer, .master_status_vector,
    .tabort_seen, .mabort_seen, .target_status_vector, .local_addr, .gnt_n,
    .idsel, .frame_n_i, .irdy_n_i, .trdy_n_i, .stop_n_i, .devsel_n_i,
    .req64_n_i, .ad_i, .cbe_i, .req_n, .frame_n_o, .irdy_n_o, .req64_n_o,
    .mst_oe_n, .ad_o, .ad_oe_n, .cbe_o, .devsel_n_o, .trdy_n_o, .ack64_n_o,
    .tgt_oe_n);
  ptsd_bus_model ptsd_bus_model_i (
    .core_clk, .rst, .mode, .req_n, .frame_n(frame_n_i), .irdy_n(irdy_n_i),
    .mst_oe_n, .gnt_n, .devsel_n(m_devsel_n), .trdy_n(m_trdy_n),
    .stop_n(m_stop_n));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // one local request, then wait until the master lets the bus go
  task automatic mreq(input ptsd_row_t r);
    logic seen;
    seen = 1'b0;
    @(posedge core_clk);
    {mode, idsel, l_adi, l_cbeni} <= {r.md, r.sel, r.adr, 4'h0, r.cmd};
    {local_request_narrow_n, local_last_request_n} <= 2'b00;
    repeat (20) if (local_addr_ack !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk);
    local_request_narrow_n <= 1'b1;
    repeat (40) begin
      @(posedge core_clk) #1;
      if (mst_oe_n === 1'b0) seen = 1'b1;
      if (seen && mst_oe_n === 1'b1 && ad_oe_n === 1'b1) break;
    end
    @(posedge core_clk);
    {local_last_request_n, idsel} <= 2'b10;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // outside master: two address phases, wide request beside frame
  task automatic dac(input logic [63:0] a, input logic hit);
    @(posedge core_clk);
    {tb_drv, tb_frame_n, tb_req64_n} <= 3'b100;
    {tb_ad, tb_cbe} <= {a, CMD_MEM_RD, CMD_DAC};
    @(posedge core_clk);
    {tb_ad, tb_cbe} <= {{2{a[63:32]}}, {2{CMD_MEM_RD}}};
    @(posedge core_clk);
    {tb_drv, tb_frame_n, tb_req64_n, tb_irdy_n} <= 4'b0110;
    #1 chk(devsel_n_o, 1'b1);
    @(posedge core_clk) #1;
    chk(devsel_n_o, !hit);
    chk(tgt_oe_n, !hit);
    chk(trdy_n_o, !hit);
    chk(ack64_n_o, !hit);
    if (hit) chk(target_status_vector, 2'b11);
    if (hit) chk(local_addr, a);
    @(posedge core_clk);
    tb_irdy_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic results();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(master_status_vector, 8'h00);
    rd(OFS_BAR0);
    chk(d, RST_BAR | 32'h4);
    rd(8'hF0);
    chk(d, 32'h0);
    wr(OFS_CMD, 32'h0);
    rd(OFS_CMD);
    chk(d[CMD_MEN_BIT], 1'b1);
    foreach (rows[k]) begin
      mreq(rows[k]);
      chk(master_status_vector, rows[k].msv);
      chk(tabort_seen, rows[k].tab);
      chk(mabort_seen, rows[k].mab);
      chk(target_status_vector, 2'b00);
    end
    rd(OFS_CMD);
    chk(d[29:28], 2'b11);
    wr(OFS_CMD, 32'h3000_0000);
    @(posedge core_clk) #1;
    chk({mabort_seen, tabort_seen}, 2'b00);
    wr(OFS_BAR0, 32'h0030_0000);
    wr(OFS_BAR1, 32'h0000_0002);
    dac(HIT, 1'b1);
    dac(HIT + 64'h1_0000_0000, 1'b0);
    results();
  end
endmodule
